// ---- testbench/host_port_peer.sv ----
// Host-side peer: packet fields toward the bank and strap pin levels
`timescale 1ns/1ps
module host_port_peer (
   input  wire logic        pull_half,
   input  wire logic        pull_fc,
   input  wire logic [4:0]  src_sel,
   input  wire logic [4:0]  dst_sel,
   input  wire logic [11:0] vid_sel,
   output logic             duplex_strap_pin,
   output logic             flowctl_strap_pin,
   output logic [4:0]       sniff_src_hit,
   output logic [4:0]       sniff_dst_hit,
   output logic [11:0]      rx_vid
);
   // Unstrapped pins fall to their pull-downs, never float
   assign duplex_strap_pin  = (pull_half === 1'b1);
   assign flowctl_strap_pin = (pull_fc === 1'b1);
   // Host sets the packet fields it directs; table setup is its duty
   assign sniff_src_hit = src_sel;
   assign sniff_dst_hit = dst_sel;
   assign rx_vid        = vid_sel;
endmodule

// ---- testbench/switch_global_control_bank_tb.sv ----
// Self-checking bench for the global control bank
`timescale 1ns/1ps
`include "gctl_params.svh"
module switch_global_control_bank_tb;
   import gctl_pkg::*;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic        reg_wr = 1'b0;
   reg_byte_t   reg_wdata = 8'h00;
   reg_byte_t   reg_rdata;
   logic        pull_half = 1'b1;
   logic        pull_fc = 1'b0;
   logic [4:0]  src_sel = 5'h00;
   logic [4:0]  dst_sel = 5'h00;
   logic [11:0] vid_sel = 12'hABD;
   logic        dup_pin, fc_pin, sniff_hit;
   logic [4:0]  src_hit, dst_hit, tag_dest_mask;
   logic [11:0] rx_vid;
   wire  [7:0]  modes;
   int          error_cnt = 0;
   int          compares = 0;
   always #2.5 clk = ~clk;
   host_port_peer peer (.pull_half(pull_half), .pull_fc(pull_fc),
      .src_sel(src_sel), .dst_sel(dst_sel), .vid_sel(vid_sel),
      .duplex_strap_pin(dup_pin), .flowctl_strap_pin(fc_pin),
      .sniff_src_hit(src_hit), .sniff_dst_hit(dst_hit), .rx_vid(rx_vid));
   switch_global_control_bank dut (.clk(clk), .nrst(nrst),
      .duplex_strap_pin(dup_pin), .flowctl_strap_pin(fc_pin),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .sniff_src_hit(src_hit),
      .sniff_dst_hit(dst_hit), .rx_vid(rx_vid), .vlan_en(modes[7]),
      .igmp_snoop_en(modes[6]), .direct_fwd_en(modes[5]),
      .pretag_en(modes[4]), .tag_mask_active(modes[3]),
      .tag_dest_mask(tag_dest_mask), .sniff_hit(sniff_hit),
      .host_bp_en(modes[2]), .host_half_duplex(modes[1]),
      .host_fc_en(modes[0]));
   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Leaves the strobe up so consecutive calls give back-to-back writes
   task automatic reg_write(input logic [7:0] a, input reg_byte_t d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
   endtask
   task automatic bus_idle;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, input reg_byte_t exp);
      @(negedge clk);
      reg_addr = a;
      #1 check_val(reg_rdata, exp);
   endtask
   task automatic restart(input logic half, input logic fc);
      @(negedge clk);
      pull_half = half;
      pull_fc = fc;
      nrst = 1'b0;
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      reg_read(`GCTL_OFS_THREE, 8'h00);
      reg_read(`GCTL_OFS_FOUR, 8'h40);
      restart(1'b0, 1'b1);
      reg_read(`GCTL_OFS_FOUR, 8'h20);
      check_val(modes, 8'h01);
      $display("test strap_defaults done");
      for (int i = 4; i < 8; i++) begin
         reg_write(`GCTL_OFS_THREE, 8'h01 << i);
         reg_write(`GCTL_OFS_FOUR, 8'h00);
         bus_idle();
         #1 check_val(modes, 8'h01 << i);
      end
      reg_write(`GCTL_OFS_THREE, 8'hFF);
      bus_idle();
      reg_read(`GCTL_OFS_THREE, 8'hF3);
      check_val(modes, 8'hF0);
      check_val({3'h0, tag_dest_mask}, 8'h00);
      reg_write(`GCTL_OFS_THREE, 8'h0C);
      bus_idle();
      reg_read(`GCTL_OFS_THREE, 8'h00);
      $display("test mode_bits done");
      reg_write(`GCTL_OFS_THREE, 8'h02);
      src_sel = 5'h04;
      bus_idle();
      #1 check_val(modes, 8'h08);
      check_val({3'h0, tag_dest_mask}, 8'h1D);
      check_val({7'h00, sniff_hit}, 8'h01);
      reg_write(`GCTL_OFS_THREE, 8'h01);
      bus_idle();
      #1 check_val({7'h00, sniff_hit}, 8'h00);
      @(negedge clk);
      dst_sel = 5'h10;
      #1 check_val({7'h00, sniff_hit}, 8'h01);
      $display("test tag_and_sniff done");
      reg_write(`GCTL_OFS_FOUR, 8'hFF);
      reg_write(8'h07, 8'hFF);
      bus_idle();
      reg_read(`GCTL_OFS_FOUR, 8'hE0);
      check_val(modes, 8'h07);
      reg_read(8'h07, 8'h00);
      reg_read(`GCTL_OFS_THREE, 8'h01);
      reg_write(`GCTL_OFS_FOUR, 8'h40);
      bus_idle();
      #1 check_val(modes, 8'h02);
      $display("test host_port done");
      tally_and_finish();
   end
endmodule

// ---- verilog/gctl_params.svh ----
// Offsets, field positions and reset values of the global control bank
`ifndef GCTL_PARAMS_SVH
`define GCTL_PARAMS_SVH
`define GCTL_OFS_THREE    8'h05
`define GCTL_OFS_FOUR     8'h06
`define GCTL_VLAN_BIT     7
`define GCTL_SNOOP_BIT    6
`define GCTL_DIRECT_BIT   5
`define GCTL_PRETAG_BIT   4
`define GCTL_TAGMASK_BIT  1
`define GCTL_SNIFF_BIT    0
`define GCTL_BP_BIT       7
`define GCTL_HALF_BIT     6
`define GCTL_FC_BIT       5
`define GCTL_THREE_WMASK  8'hF3
`define GCTL_FOUR_WMASK   8'hE0
`define GCTL_THREE_RESET  8'h00
`define GCTL_FOUR_RESET   8'h00
`endif

// ---- verilog/gctl_pkg.sv ----
// Types shared by the global control bank
package gctl_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef enum logic [1:0] {
      STRAP_IDLE = 2'b00,
      STRAP_LOAD = 2'b01,
      STRAP_DONE = 2'b10
   } strap_state_t;
endpackage

// ---- verilog/strap_capture.sv ----
// Catches strap pin levels once after reset release
`timescale 1ns/1ps
`include "gctl_params.svh"
module strap_capture (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic duplex_strap_pin,
   input  wire logic flowctl_strap_pin,
   output logic      load_pulse,
   output logic      strap_half,
   output logic      strap_fc
);
   import gctl_pkg::*;
   strap_state_t state;
   strap_state_t next_state;
   logic         next_half;
   logic         next_fc;

   // Straps are sampled by a clocked process after release, never by reset
   always_comb begin
      next_state = state;
      next_half  = strap_half;
      next_fc    = strap_fc;
      unique case (state)
         STRAP_IDLE: begin
            next_state = STRAP_LOAD;
            next_half  = duplex_strap_pin;
            next_fc    = flowctl_strap_pin;
         end
         STRAP_LOAD: next_state = STRAP_DONE;
         STRAP_DONE: next_state = STRAP_DONE;
         default:    next_state = STRAP_DONE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state      <= STRAP_IDLE;
         strap_half <= 1'b0;
         strap_fc   <= 1'b0;
      end else begin
         state      <= next_state;
         strap_half <= next_half;
         strap_fc   <= next_fc;
      end
   end

   assign load_pulse = (state == STRAP_LOAD);

   // A repeated load would clobber a later host write
   property p_load_once;
      @(posedge clk) disable iff (!nrst)
      load_pulse |=> !load_pulse [*8];
   endproperty
   a_load_once: assert property (p_load_once) // see R12 R14
      else $error("strap load repeated");
endmodule

// ---- verilog/switch_global_control_bank.sv ----
// Global control registers 0x05 and 0x06 of the switch with decoded modes
//
// What this block does
// R01 - Register 0x05 bit 7 enables 802.1q VLAN; resets to zero.
// R02 - Host programs the VLAN table before setting VLAN enable.
// R03 - Bit 6 set forwards every IGMP packet to the host port.
// R04 - Bit 5 set forwards host packets by preamble, bypassing lookup.
// R05 - Bit 4 set prefixes host-bound packets with source port number.
// R06 - Bit 1 set uses low five VID bits as destination mask.
// R07 - Tag mask acts only while VLAN enable is clear.
// R08 - Bit 0 set sniffs on source AND destination match, else either.
// R09 - Either-port sniff (bit 0 clear) realises receive-only sniffing.
// R10 - Register 6 bit 7 enables host port half-duplex back pressure.
// R11 - Register 6 bit 6 selects half duplex, clear is full.
// R12 - Duplex reset value comes from the duplex strap pin.
// R13 - Register 6 bit 5 enables host port full-duplex flow control.
// R14 - Flow control reset value comes from the flow control strap.
// R15 - Reserved bits 3..2 of 0x05 read zero; others read back.
`timescale 1ns/1ps
`include "gctl_params.svh"
module switch_global_control_bank #(
   parameter int PORTS = 5
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic             duplex_strap_pin,
   input  wire logic             flowctl_strap_pin,
   input  wire logic [7:0]       reg_addr,
   input  wire logic             reg_wr,
   input  wire gctl_pkg::reg_byte_t reg_wdata,
   output gctl_pkg::reg_byte_t   reg_rdata,
   input  wire logic [PORTS-1:0] sniff_src_hit,
   input  wire logic [PORTS-1:0] sniff_dst_hit,
   input  wire logic [11:0]      rx_vid,
   output logic                  vlan_en,
   output logic                  igmp_snoop_en,
   output logic                  direct_fwd_en,
   output logic                  pretag_en,
   output logic                  tag_mask_active,
   output logic [PORTS-1:0]      tag_dest_mask,
   output logic                  sniff_hit,
   output logic                  host_bp_en,
   output logic                  host_half_duplex,
   output logic                  host_fc_en
);
   import gctl_pkg::*;
   reg_byte_t ctl_three;
   reg_byte_t ctl_four;
   reg_byte_t next_three;
   reg_byte_t next_four;
   logic      load_pulse;
   logic      strap_half;
   logic      strap_fc;

   function automatic logic hit_reg(input logic [7:0] a, input logic [7:0] o);
      hit_reg = (a == o);
   endfunction

   strap_capture u_strap (
      .clk               (clk),
      .nrst              (nrst),
      .duplex_strap_pin  (duplex_strap_pin),
      .flowctl_strap_pin (flowctl_strap_pin),
      .load_pulse        (load_pulse),
      .strap_half        (strap_half),
      .strap_fc          (strap_fc)
   );

   always_comb begin
      next_three = ctl_three;
      next_four  = ctl_four;
      if (reg_wr && hit_reg(reg_addr, `GCTL_OFS_THREE)) begin
         next_three = reg_wdata & `GCTL_THREE_WMASK; // see R15
      end
      if (load_pulse) begin
         next_four[`GCTL_HALF_BIT] = strap_half; // see R12
         next_four[`GCTL_FC_BIT]   = strap_fc;   // see R14
      end
      // A host write in the load cycle overrides the strap value
      if (reg_wr && hit_reg(reg_addr, `GCTL_OFS_FOUR)) begin
         next_four = reg_wdata & `GCTL_FOUR_WMASK;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctl_three <= `GCTL_THREE_RESET; // see R01
         ctl_four  <= `GCTL_FOUR_RESET;
      end else begin
         ctl_three <= next_three;
         ctl_four  <= next_four;
      end
   end

   always_comb begin
      reg_rdata = 8'h00;
      if (hit_reg(reg_addr, `GCTL_OFS_THREE)) begin
         reg_rdata = ctl_three; // see R15
      end else if (hit_reg(reg_addr, `GCTL_OFS_FOUR)) begin
         reg_rdata = ctl_four;
      end
   end

   // Table contents are the host's duty before enabling VLAN (see R02)
   assign vlan_en          = ctl_three[`GCTL_VLAN_BIT];    // see R01
   assign igmp_snoop_en    = ctl_three[`GCTL_SNOOP_BIT];   // see R03
   assign direct_fwd_en    = ctl_three[`GCTL_DIRECT_BIT];  // see R04
   assign pretag_en        = ctl_three[`GCTL_PRETAG_BIT];  // see R05
   assign tag_mask_active  = ctl_three[`GCTL_TAGMASK_BIT]
                             && !vlan_en;                  // see R07
   assign tag_dest_mask    = tag_mask_active ?
                             rx_vid[PORTS-1:0] : '0;       // see R06
   // AND mode needs both ends; OR mode gives receive-only sniff
   assign sniff_hit = ctl_three[`GCTL_SNIFF_BIT] ?
                      (|sniff_src_hit && |sniff_dst_hit) :  // see R08
                      (|sniff_src_hit || |sniff_dst_hit);   // see R09
   assign host_bp_en       = ctl_four[`GCTL_BP_BIT];       // see R10
   assign host_half_duplex = ctl_four[`GCTL_HALF_BIT];     // see R11
   assign host_fc_en       = ctl_four[`GCTL_FC_BIT];       // see R13

   property p_reserved_zero;
      @(posedge clk) disable iff (!nrst)
      hit_reg(reg_addr, `GCTL_OFS_THREE) |-> reg_rdata[3:2] == 2'b00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // see R15
      else $error("reserved bits nonzero");

   property p_write_three;
      @(posedge clk) disable iff (!nrst)
      (reg_wr && hit_reg(reg_addr, `GCTL_OFS_THREE)) |=>
         ctl_three == ($past(reg_wdata) & `GCTL_THREE_WMASK);
   endproperty
   a_write_three: assert property (p_write_three) // see R01
      else $error("register 0x05 write lost");

   property p_tagmask_vlan;
      @(posedge clk) disable iff (!nrst)
      vlan_en |-> tag_dest_mask == '0;
   endproperty
   a_tagmask_vlan: assert property (p_tagmask_vlan) // see R07
      else $error("tag mask active with VLAN on");

   property p_sniff_or;
      @(posedge clk) disable iff (!nrst)
      (!ctl_three[`GCTL_SNIFF_BIT] && |sniff_src_hit) |-> sniff_hit;
   endproperty
   a_sniff_or: assert property (p_sniff_or) // see R09
      else $error("receive-only sniff missed");

   property p_sniff_and;
      @(posedge clk) disable iff (!nrst)
      (ctl_three[`GCTL_SNIFF_BIT] && !(|sniff_dst_hit)) |-> !sniff_hit;
   endproperty
   a_sniff_and: assert property (p_sniff_and) // see R08
      else $error("AND sniff fired on one side");

   sequence s_strap_load;
      load_pulse && !reg_wr;
   endsequence
   property p_strap_duplex;
      @(posedge clk) disable iff (!nrst)
      s_strap_load |=> host_half_duplex == $past(strap_half);
   endproperty
   a_strap_duplex: assert property (p_strap_duplex) // see R12
      else $error("duplex strap not loaded");

   property p_strap_fc;
      @(posedge clk) disable iff (!nrst)
      s_strap_load |=> host_fc_en == $past(strap_fc);
   endproperty
   a_strap_fc: assert property (p_strap_fc) // see R14
      else $error("flow control strap not loaded");

   property p_write_four;
      @(posedge clk) disable iff (!nrst)
      (reg_wr && hit_reg(reg_addr, `GCTL_OFS_FOUR)) |=>
         host_bp_en == $past(reg_wdata[`GCTL_BP_BIT]) &&
         host_half_duplex == $past(reg_wdata[`GCTL_HALF_BIT]);
   endproperty
   a_write_four: assert property (p_write_four) // see R10
      else $error("register 0x06 write lost");

   sequence s_write_four;
      reg_wr && hit_reg(reg_addr, `GCTL_OFS_FOUR);
   endsequence
   property p_write_fc;
      @(posedge clk) disable iff (!nrst)
      s_write_four |=> host_fc_en == $past(reg_wdata[`GCTL_FC_BIT]);
   endproperty
   a_write_fc: assert property (p_write_fc) // see R13
      else $error("flow control write lost");

   // Only the upper three bits of 0x06 exist
   property p_four_low_zero;
      @(posedge clk) disable iff (!nrst)
      hit_reg(reg_addr, `GCTL_OFS_FOUR) |-> reg_rdata[4:0] == 5'h00;
   endproperty
   a_four_low_zero: assert property (p_four_low_zero) // see R15
      else $error("absent bits of 0x06 nonzero");

   property p_unmapped_zero;
      @(posedge clk) disable iff (!nrst)
      !hit_reg(reg_addr, `GCTL_OFS_THREE) &&
         !hit_reg(reg_addr, `GCTL_OFS_FOUR) |-> reg_rdata == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) // see R15
      else $error("unmapped address read nonzero");

   property p_tagmask_on;
      @(posedge clk) disable iff (!nrst)
      (ctl_three[`GCTL_TAGMASK_BIT] && !ctl_three[`GCTL_VLAN_BIT]) |->
         tag_dest_mask == rx_vid[PORTS-1:0];
   endproperty
   a_tagmask_on: assert property (p_tagmask_on) // see R06
      else $error("tag mask not taken from VID");

   property p_sniff_both;
      @(posedge clk) disable iff (!nrst)
      (ctl_three[`GCTL_SNIFF_BIT] && |sniff_src_hit && |sniff_dst_hit) |->
         sniff_hit;
   endproperty
   a_sniff_both: assert property (p_sniff_both) // see R08
      else $error("AND sniff missed a full match");

   // Register 0x05 settings must not drift between host writes
   property p_hold_three;
      @(posedge clk) disable iff (!nrst)
      !(reg_wr && hit_reg(reg_addr, `GCTL_OFS_THREE)) |=>
         $stable(ctl_three);
   endproperty
   a_hold_three: assert property (p_hold_three) // see R15
      else $error("register 0x05 changed without a write");

   sequence s_write_three;
      reg_wr && hit_reg(reg_addr, `GCTL_OFS_THREE);
   endsequence
   property p_write_modes;
      @(posedge clk) disable iff (!nrst)
      s_write_three |=>
         igmp_snoop_en == $past(reg_wdata[`GCTL_SNOOP_BIT]) &&
         direct_fwd_en == $past(reg_wdata[`GCTL_DIRECT_BIT]) &&
         pretag_en == $past(reg_wdata[`GCTL_PRETAG_BIT]);
   endproperty
   a_write_modes: assert property (p_write_modes) // see R03 R04 R05
      else $error("mode bit write lost");
endmodule
